// file: bench/tb_wse_seq.sv
// Self-checking bench for the windowed exception sequencer
`timescale 1ns/1ps
module tb_wse_seq
   import wse_pkg::*;
();
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, irq, raise, ack;
   logic        busy, exc_taken, link_we, pc_load;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [5:0]  irq_number, raise_num, exc_number;
   logic [4:0]  link_window;
   logic [15:0] link_register, handler_pc;
   wse_instr_t  instr;
   wse_status_t status_word;
   int          fail_count, checked;

   wse_seq u_wse_seq (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .instr,
      .irq, .irq_number, .busy, .exc_taken, .exc_number, .link_we, .link_window,
      .link_register, .pc_load, .handler_pc, .status_word
   );

   wse_irq_src u_wse_irq_src (
      .aclk, .aresetn, .raise, .number(raise_num), .ack, .irq, .irq_number
   );

   always #2 aclk = ~aclk;

   function automatic logic [15:0] st(input logic en, input logic [5:0] p, input logic [4:0] w);
      return {en, 4'h0, p, w};
   endfunction : st

   function automatic logic [15:0] vec(input logic [5:0] n);
      return 16'h0400 + {n, 4'h0};
   endfunction : vec

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w;
      aw = 1'h0;
      w = 1'h0;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid  <= 1'h1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (!aw && s_axi_awready === 1'h1) begin
            aw = 1'h1;
            s_axi_awvalid <= 1'h0;
         end
         if (!w && s_axi_wready === 1'h1) begin
            w = 1'h1;
            s_axi_wvalid <= 1'h0;
         end
      end
      s_axi_bready <= 1'h1;
      do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
      chk("bresp", er, s_axi_bresp);
   endtask : axi_wr

   task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      do @(posedge aclk); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      s_axi_rready  <= 1'h1;
      do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
      chk("rresp", er, s_axi_rresp);
      chk("rdata", ed, s_axi_rdata);
   endtask : axi_rd

   // Presents one instruction and returns at the edge that takes it
   task automatic put(input wse_op_t op, input logic [5:0] n, input logic [15:0] wd);
      instr <= {1'h1, op, n, 16'h0200, 16'h0202, wd};
      @(posedge aclk);
   endtask : put

   // Interrupts return to the presented instruction, the rest to the one after it
   task automatic entry(input logic [5:0] n, input logic [4:0] w, input logic [15:0] lk);
      chk("exc_number", n, exc_number);
      chk("busy", 1'h1, busy);
      chk("link_we", 1'h1, link_we);
      chk("link_window", w, link_window);
      chk("link_register", lk, link_register);
      @(negedge aclk);
      chk("pc_load", 1'h1, pc_load);
      chk("busy_end", 1'h0, busy);
      chk("exc_pulse", 1'h0, exc_taken);
      chk("handler_pc", {vec(n), 1'h0}, handler_pc);
   endtask : entry

   task automatic run(input wse_op_t op, input logic [5:0] n, input logic [15:0] wd,
                      input logic e, input logic [15:0] s);
      @(posedge aclk);
      while (busy !== 1'h0) @(posedge aclk);
      put(op, n, wd);
      instr.valid <= 1'h0;
      @(negedge aclk);
      chk("exc_taken", e, exc_taken);
      chk("status", s, status_word);
      if (e) begin
         entry(n, s[4:0], 16'h0101);
      end
   endtask : run

   task automatic irq_ctl(input logic r, input logic [5:0] n);
      @(posedge aclk);
      raise     <= r;
      ack       <= !r;
      raise_num <= n;
      @(posedge aclk);
      raise <= 1'h0;
      ack   <= 1'h0;
   endtask : irq_ctl

   task automatic watch(input int cyc, input logic e);
      for (int k = 0; k < cyc && exc_taken !== 1'h1; k++) @(negedge aclk);
      chk("irq_taken", e, exc_taken);
   endtask : watch

   task automatic t_regs();
      axi_rd(STATUS_OFS, 32'h0000_07FE, RESP_OKAY);
      axi_rd(LIMITS_OFS, 32'h0000_1E01, RESP_OKAY);
      axi_wr(STATUS_OFS, 32'h0000_FFFF, RESP_OKAY);
      axi_rd(STATUS_OFS, 32'h0000_07FE, RESP_OKAY);
      axi_wr(12'h00C, 32'h0000_1234, RESP_SLVERR);
      axi_rd(12'h00C, 32'h0000_0000, RESP_SLVERR);
      for (int i = 0; i < 64; i++) begin
         axi_wr(VEC_OFS + 12'(4 * i), {16'h0000, vec(6'(i))}, RESP_OKAY);
      end
      axi_rd(VEC_OFS + 12'h0A8, {16'h0000, vec(6'h2A)}, RESP_OKAY);
      $display("register test done");
   endtask : t_regs

   task automatic t_trap();
      run(OP_CONTROL_WRITE, 6'h00, st(1'h0, 6'h03, 5'h0A), 1'h0, st(1'h0, 6'h03, 5'h0A));
      run(OP_TRAP, 6'h2A, 16'h0000, 1'h1, st(1'h0, 6'h2A, 5'h09));
      axi_rd(SAVED_OFS, {16'h0000, st(1'h0, 6'h03, 5'h0A)}, RESP_OKAY);
      run(OP_EXCEPTION_RETURN, 6'h00, 16'h0000, 1'h0, st(1'h0, 6'h03, 5'h0A));
      $display("trap test done");
   endtask : t_trap

   task automatic t_under();
      run(OP_CONTROL_WRITE, 6'h00, st(1'h1, 6'h0A, 5'h01), 1'h0, st(1'h1, 6'h0A, 5'h01));
      run(OP_SAVE, 6'h01, 16'h0000, 1'h1, st(1'h0, 6'h01, 5'h00));
      run(OP_CONTROL_WRITE, 6'h00, st(1'h0, 6'h0A, 5'h01), 1'h0, st(1'h0, 6'h0A, 5'h01));
      run(OP_SAVE, 6'h01, 16'h0000, 1'h0, st(1'h0, 6'h0A, 5'h00));
      run(OP_CONTROL_WRITE, 6'h00, st(1'h1, 6'h01, 5'h01), 1'h0, st(1'h1, 6'h01, 5'h01));
      run(OP_SAVE, 6'h01, 16'h0000, 1'h0, st(1'h1, 6'h01, 5'h00));
      run(OP_CONTROL_WRITE, 6'h00, st(1'h1, 6'h0A, 5'h00), 1'h0, st(1'h1, 6'h0A, 5'h00));
      run(OP_SAVE, 6'h01, 16'h0000, 1'h0, st(1'h1, 6'h0A, 5'h1F));
      $display("underflow test done");
   endtask : t_under

   task automatic t_over();
      axi_wr(LIMITS_OFS, 32'h0000_1001, RESP_OKAY);
      axi_rd(LIMITS_OFS, 32'h0000_1001, RESP_OKAY);
      run(OP_CONTROL_WRITE, 6'h00, st(1'h0, 6'h3F, 5'h10), 1'h0, st(1'h0, 6'h3F, 5'h10));
      run(OP_RESTORE, 6'h02, 16'h0000, 1'h1, st(1'h0, 6'h02, 5'h10));
      run(OP_CONTROL_WRITE, 6'h00, st(1'h0, 6'h3F, 5'h12), 1'h0, st(1'h0, 6'h3F, 5'h12));
      run(OP_RESTORE, 6'h02, 16'h0000, 1'h0, st(1'h0, 6'h3F, 5'h13));
      $display("overflow test done");
   endtask : t_over

   task automatic t_irq();
      run(OP_CONTROL_WRITE, 6'h00, st(1'h1, 6'h0A, 5'h10), 1'h0, st(1'h1, 6'h0A, 5'h10));
      irq_ctl(1'h1, 6'h0A);
      watch(8, 1'h0);
      irq_ctl(1'h0, 6'h00);
      irq_ctl(1'h1, 6'h03);
      watch(10, 1'h1);
      chk("status", st(1'h0, 6'h03, 5'h0F), status_word);
      // No instruction is presented, so the stale one is the preempted one
      entry(6'h03, 5'h0F, 16'h0100);
      irq_ctl(1'h0, 6'h00);
      irq_ctl(1'h1, 6'h03);
      repeat (3) @(posedge aclk);
      // Enable and underflow meet the pending request on the same edge
      put(OP_CONTROL_WRITE, 6'h00, st(1'h1, 6'h0A, 5'h01));
      put(OP_SAVE, 6'h01, 16'h0000);
      instr.valid <= 1'h0;
      @(negedge aclk);
      chk("exc_taken", 1'h1, exc_taken);
      chk("status", st(1'h0, 6'h01, 5'h00), status_word);
      entry(6'h01, 5'h00, 16'h0101);
      watch(6, 1'h0);
      irq_ctl(1'h0, 6'h00);
      $display("interrupt test done");
   endtask : t_irq

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      #80000;
      fail_count++;
      report_and_stop();
   end

   initial begin
      aclk = 1'h0;
      aresetn = 1'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 12'h000;
      s_axi_araddr = 12'h000;
      s_axi_wdata = 32'h0000_0000;
      instr = '0;
      {raise, ack} = 2'h0;
      raise_num = 6'h00;
      fail_count = 0;
      checked = 0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      t_regs();
      t_trap();
      t_under();
      t_over();
      t_irq();
      report_and_stop();
   end
endmodule : tb_wse_seq

// file: bench/wse_irq_src.sv
// Interrupt requester model for the exception sequencer bench
`timescale 1ns/1ps
module wse_irq_src (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       raise,
   input  wire logic [5:0] number,
   input  wire logic       ack,
   output logic            irq,
   output logic [5:0]      irq_number
);
   logic [5:0] last_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq    <= 1'h0;
         last_q <= 6'h00;
      end else if (ack) begin
         irq <= 1'h0;
      end else if (raise) begin
         irq    <= 1'h1;
         last_q <= number;
      end
   end

   // Released number lines show the inverse, so a stale number never looks valid
   assign irq_number = irq ? last_q : ~last_q;
endmodule : wse_irq_src

// file: verilog/wse_pkg.sv
// Package for the windowed exception sequencer
// Functional notes
// RQ1 - Underflow decrements window pointer exactly once
// RQ2 - Underflow uses exception number one
// RQ3 - Underflow needs enable set, threshold above one
// RQ4 - Only window open raises underflow
// RQ5 - Open below low limit raises nothing
// RQ6 - Close at high limit raises overflow immediately
// RQ7 - Overflow number two, pointer stays high limit
// RQ8 - Only window close at limit raises overflow
// RQ9 - Trap number from field, always taken
// RQ10 - Trap skips next, saves it as return
// RQ11 - Entry first copies status to saved status
// RQ12 - Entry opens window except for overflow
// RQ13 - Entry clears enable, loads threshold with number
// RQ14 - Return location is the preempted instruction
// RQ15 - Link register gets halved return address
// RQ16 - Handler address fetched from vector table
// RQ17 - Return restores whole status from saved copy
// RQ18 - Low window limit resets to one
// RQ19 - Last-window underflow handler runs at pointer zero
// RQ20 - Vector entry doubled before loading program counter
// RQ21 - Request taken if enabled and number below threshold
// RQ22 - Level request and number sampled every edge
// RQ23 - Instruction exception beats coincident external request
// RQ24 - Entry updates complete before handler fetch
package wse_pkg;
   localparam logic [11:0] STATUS_OFS = 12'h000;
   localparam logic [11:0] SAVED_OFS  = 12'h004;
   localparam logic [11:0] LIMITS_OFS = 12'h008;
   localparam logic [11:0] VEC_OFS    = 12'h100;
   // Status word fields
   localparam int WINDOW_LSB = 0;
   localparam int THRESH_LSB = 5;
   localparam int ENABLE_POS = 15;
   // Limits register fields
   localparam int LO_LSB = 0;
   localparam int HI_LSB = 8;
   localparam logic [4:0]  LO_RESET     = 5'h01;
   localparam logic [4:0]  HI_RESET     = 5'h1E;
   localparam logic [4:0]  WINDOW_RESET = 5'h1E;
   localparam logic [5:0]  THRESH_RESET = 6'h3F;
   localparam logic [5:0]  EXC_UNDER    = 6'h01;
   localparam logic [5:0]  EXC_OVER     = 6'h02;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   typedef enum logic [2:0] {
      OP_NONE, OP_SAVE, OP_RESTORE, OP_TRAP, OP_EXCEPTION_RETURN, OP_CONTROL_WRITE
   } wse_op_t;

   typedef struct packed {
      logic        interrupt_enable_bit;
      logic [3:0]  spare;
      logic [5:0]  priority_threshold;
      logic [4:0]  current_window_pointer;
   } wse_status_t;

   typedef struct packed {
      logic        valid;
      wse_op_t     op;
      logic [5:0]  trap_number_field;
      logic [15:0] addr;
      logic [15:0] next_addr;
      wse_status_t wdata;
   } wse_instr_t;
endpackage : wse_pkg

// file: verilog/wse_seq.sv
// Exception entry and return sequencer with AXI4-Lite register access
`timescale 1ns/1ps
module wse_seq
   import wse_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire wse_instr_t  instr,
   input  wire logic        irq,
   input  wire logic [5:0]  irq_number,
   output logic             busy,
   output logic             exc_taken,
   output logic [5:0]       exc_number,
   output logic             link_we,
   output logic [4:0]       link_window,
   output logic [15:0]      link_register,
   output logic             pc_load,
   output logic [15:0]      handler_pc,
   output wse_status_t      status_word
);

   typedef enum logic {ST_IDLE, ST_VEC} wse_state_t;

   function automatic logic is_vec(input logic [11:0] a);
      return a[11:8] == VEC_OFS[11:8] && a[1:0] == 2'h0 && a[7:2] <= 6'h3F;
   endfunction : is_vec

   logic [15:0] vec_mem [64];

   wse_state_t  state_q, state_d;
   wse_status_t status_q, status_d;
   wse_status_t saved_q, saved_d;
   logic [4:0]  lo_q, lo_d, hi_q, hi_d;
   logic        busy_q, busy_d;
   logic        exc_q, exc_d;
   logic [5:0]  num_q, num_d;
   logic        lwe_q, lwe_d;
   logic [4:0]  lwin_q, lwin_d;
   logic [15:0] link_q, link_d;
   logic        pcl_q, pcl_d;
   logic [15:0] hpc_q, hpc_d;
   logic        irq_q, irq_d;
   logic [5:0]  irqn_q, irqn_d;

   logic        aw_h_q, aw_h_d, w_h_q, w_h_d;
   logic [11:0] aw_a_q, aw_a_d;
   logic [31:0] w_d_q, w_d_d;
   logic [3:0]  w_s_q, w_s_d;
   logic        awr_q, awr_d, wr_q, wr_d;
   logic        bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
   logic [1:0]  br_q, br_d, rr_q, rr_d;
   logic [31:0] rd_q, rd_d;
   logic        vec_we;

   logic        under, over, trap, take_irq, take;
   logic [5:0]  take_num;
   logic [15:0] ret_addr;

   // Request level and number are registered on every edge
   assign irq_d  = irq; // RQ22
   assign irqn_d = irq_number; // RQ22

   // Instruction exceptions, decided from the presented instruction
   always_comb begin
      under = 1'b0;
      over  = 1'b0;
      trap  = 1'b0;
      if (instr.valid && !busy_q) begin
         // Only an open at exactly the low limit, never below it
         under = instr.op == OP_SAVE
                 && status_q.current_window_pointer == lo_q // RQ4 RQ5
                 && status_q.interrupt_enable_bit // RQ3
                 && status_q.priority_threshold > EXC_UNDER; // RQ3
         over  = instr.op == OP_RESTORE
                 && status_q.current_window_pointer == hi_q; // RQ6 RQ8
         trap  = instr.op == OP_TRAP; // RQ9
      end
   end

   // External request loses to any instruction exception and stays pending
   assign take_irq = !busy_q && !(under || over || trap) // RQ23
                     && irq_q && status_q.interrupt_enable_bit // RQ21
                     && irqn_q < status_q.priority_threshold; // RQ21
   assign take = under || over || trap || take_irq;

   always_comb begin
      if (under)
         take_num = EXC_UNDER; // RQ2
      else if (over)
         take_num = EXC_OVER; // RQ7
      else if (trap)
         take_num = instr.trap_number_field; // RQ9
      else
         take_num = irqn_q;
   end

   // Interrupt preempts the presented instruction; others resume after it
   assign ret_addr = take_irq ? instr.addr : instr.next_addr; // RQ14 RQ10

   always_comb begin
      state_d  = state_q;
      status_d = status_q;
      saved_d  = saved_q;
      busy_d   = busy_q;
      exc_d    = 1'b0;
      num_d    = num_q;
      lwe_d    = 1'b0;
      lwin_d   = lwin_q;
      link_d   = link_q;
      pcl_d    = 1'b0;
      hpc_d    = hpc_q;
      case (state_q)
         ST_IDLE: begin
            if (take) begin
               // All entry updates land on one edge, before any fetch
               saved_d = status_q; // RQ11 RQ24
               // Overflow keeps the pointer: the close and the entry cancel out
               if (over)
                  status_d.current_window_pointer = status_q.current_window_pointer; // RQ7
               else
                  status_d.current_window_pointer =
                     status_q.current_window_pointer - 5'h01; // RQ1 RQ12 RQ19
               status_d.interrupt_enable_bit = 1'b0; // RQ13
               status_d.priority_threshold   = take_num; // RQ13
               lwin_d  = status_d.current_window_pointer; // RQ15
               link_d  = {1'b0, ret_addr[15:1]}; // RQ15
               lwe_d   = 1'b1;
               exc_d   = 1'b1;
               num_d   = take_num;
               busy_d  = 1'b1;
               state_d = ST_VEC;
            end else if (instr.valid && !busy_q) begin
               case (instr.op)
                  OP_SAVE: begin
                     status_d.current_window_pointer = status_q.current_window_pointer - 5'h01;
                  end
                  OP_RESTORE: begin
                     status_d.current_window_pointer = status_q.current_window_pointer + 5'h01;
                  end
                  OP_EXCEPTION_RETURN: status_d = saved_q; // RQ17
                  // Direct write never raises an exception
                  OP_CONTROL_WRITE:    status_d = instr.wdata; // RQ4 RQ8
                  default:    status_d = status_q;
               endcase
            end
         end
         ST_VEC: begin
            hpc_d   = {vec_mem[num_q][14:0], 1'b0}; // RQ16 RQ20
            pcl_d   = 1'b1;
            busy_d  = 1'b0;
            state_d = ST_IDLE;
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // AXI4-Lite write: address and data latched in either order
   always_comb begin
      aw_h_d = aw_h_q;
      aw_a_d = aw_a_q;
      w_h_d  = w_h_q;
      w_d_d  = w_d_q;
      w_s_d  = w_s_q;
      bv_d   = bv_q;
      br_d   = br_q;
      lo_d   = lo_q;
      hi_d   = hi_q;
      vec_we = 1'b0;
      if (s_axi_awvalid && awr_q) begin
         aw_h_d = 1'b1;
         aw_a_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && wr_q) begin
         w_h_d = 1'b1;
         w_d_d = s_axi_wdata;
         w_s_d = s_axi_wstrb;
      end
      if (bv_q && s_axi_bready)
         bv_d = 1'b0;
      if (aw_h_q && w_h_q && !bv_q) begin
         aw_h_d = 1'b0;
         w_h_d  = 1'b0;
         bv_d   = 1'b1;
         br_d   = RESP_OKAY;
         if (aw_a_q == LIMITS_OFS) begin
            if (w_s_q[0])
               lo_d = w_d_q[LO_LSB +: 5];
            if (w_s_q[1])
               hi_d = w_d_q[HI_LSB +: 5];
         end else if (is_vec(aw_a_q)) begin
            vec_we = 1'b1;
         end else if (aw_a_q != STATUS_OFS && aw_a_q != SAVED_OFS) begin
            br_d = RESP_SLVERR;
         end
      end
      awr_d = !aw_h_d && !bv_d;
      wr_d  = !w_h_d && !bv_d;
   end

   // AXI4-Lite read: one outstanding, answered on the same edge that accepts the address
   always_comb begin
      rv_d = rv_q;
      rd_d = rd_q;
      rr_d = rr_q;
      if (rv_q && s_axi_rready)
         rv_d = 1'b0;
      if (s_axi_arvalid && arr_q) begin
         rv_d = 1'b1;
         rr_d = RESP_OKAY;
         rd_d = 32'h0000_0000;
         if (s_axi_araddr == STATUS_OFS)
            rd_d[15:0] = status_q;
         else if (s_axi_araddr == SAVED_OFS)
            rd_d[15:0] = saved_q;
         else if (s_axi_araddr == LIMITS_OFS) begin
            rd_d[LO_LSB +: 5] = lo_q;
            rd_d[HI_LSB +: 5] = hi_q;
         end else if (is_vec(s_axi_araddr))
            rd_d[15:0] = vec_mem[s_axi_araddr[7:2]];
         else
            rr_d = RESP_SLVERR;
      end
      arr_d = !rv_d;
   end

   // Vector table is plain storage and keeps its contents over reset
   always_ff @(posedge aclk) begin
      if (vec_we) begin
         if (w_s_q[0])
            vec_mem[aw_a_q[7:2]][7:0] <= w_d_q[7:0];
         if (w_s_q[1])
            vec_mem[aw_a_q[7:2]][15:8] <= w_d_q[15:8];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q  <= ST_IDLE;
         status_q <= '{interrupt_enable_bit: 1'b0,
                       spare: 4'h0,
                       priority_threshold: THRESH_RESET,
                       current_window_pointer: WINDOW_RESET};
         saved_q  <= '0;
         lo_q     <= LO_RESET; // RQ18
         hi_q     <= HI_RESET;
         busy_q   <= 1'b0;
         exc_q    <= 1'b0;
         num_q    <= 6'h00;
         lwe_q    <= 1'b0;
         lwin_q   <= 5'h00;
         link_q   <= 16'h0000;
         pcl_q    <= 1'b0;
         hpc_q    <= 16'h0000;
         irq_q    <= 1'b0;
         irqn_q   <= 6'h00;
         aw_h_q   <= 1'b0;
         aw_a_q   <= 12'h000;
         w_h_q    <= 1'b0;
         w_d_q    <= 32'h0000_0000;
         w_s_q    <= 4'h0;
         awr_q    <= 1'b0;
         wr_q     <= 1'b0;
         bv_q     <= 1'b0;
         br_q     <= RESP_OKAY;
         arr_q    <= 1'b0;
         rv_q     <= 1'b0;
         rr_q     <= RESP_OKAY;
         rd_q     <= 32'h0000_0000;
      end else begin
         state_q  <= state_d;
         status_q <= status_d;
         saved_q  <= saved_d;
         lo_q     <= lo_d;
         hi_q     <= hi_d;
         busy_q   <= busy_d;
         exc_q    <= exc_d;
         num_q    <= num_d;
         lwe_q    <= lwe_d;
         lwin_q   <= lwin_d;
         link_q   <= link_d;
         pcl_q    <= pcl_d;
         hpc_q    <= hpc_d;
         irq_q    <= irq_d;
         irqn_q   <= irqn_d;
         aw_h_q   <= aw_h_d;
         aw_a_q   <= aw_a_d;
         w_h_q    <= w_h_d;
         w_d_q    <= w_d_d;
         w_s_q    <= w_s_d;
         awr_q    <= awr_d;
         wr_q     <= wr_d;
         bv_q     <= bv_d;
         br_q     <= br_d;
         arr_q    <= arr_d;
         rv_q     <= rv_d;
         rr_q     <= rr_d;
         rd_q     <= rd_d;
      end
   end

   assign s_axi_awready = awr_q;
   assign s_axi_wready  = wr_q;
   assign s_axi_bvalid  = bv_q;
   assign s_axi_bresp   = br_q;
   assign s_axi_arready = arr_q;
   assign s_axi_rvalid  = rv_q;
   assign s_axi_rresp   = rr_q;
   assign s_axi_rdata   = rd_q;
   assign busy          = busy_q;
   assign exc_taken     = exc_q;
   assign exc_number    = num_q;
   assign link_we       = lwe_q;
   assign link_window   = lwin_q;
   assign link_register = link_q;
   assign pc_load       = pcl_q;
   assign handler_pc    = hpc_q;
   assign status_word   = status_q;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_under_once: assert property (under |=> // RQ1
      status_q.current_window_pointer == $past(status_q.current_window_pointer) - 5'h01)
      else $error("underflow entry moved pointer wrongly");
   a_under_num: assert property (under |=> exc_taken && exc_number == 6'h01) // RQ2
      else $error("underflow number wrong");
   a_under_gate: assert property (exc_taken && exc_number == 6'h01 // RQ3
      && $past(instr.op == OP_SAVE) |-> $past(status_q.interrupt_enable_bit)
      && $past(status_q.priority_threshold) > 6'h01)
      else $error("underflow taken while masked");
   a_direct_quiet: assert property (instr.valid && !busy_q // RQ4
      && instr.op == OP_CONTROL_WRITE && !take_irq |=> !exc_taken)
      else $error("direct write raised an exception");
   // A request numbered one may still be taken here, so it is left out
   a_below_quiet: assert property (instr.valid && !busy_q && instr.op == OP_SAVE // RQ5
      && status_q.current_window_pointer < lo_q && !take_irq
      |=> !(exc_taken && exc_number == 6'h01))
      else $error("open below limit raised underflow");
   a_over_stay: assert property (over |=> exc_taken && exc_number == 6'h02 // RQ6 RQ7
      && status_q.current_window_pointer == hi_q)
      else $error("overflow entry wrong");
   a_trap_num: assert property (trap |=> exc_taken // RQ9
      && exc_number == $past(instr.trap_number_field))
      else $error("trap number wrong");
   a_entry_state: assert property (take |=> !status_q.interrupt_enable_bit // RQ11 RQ13
      && saved_q == $past(status_q) && status_q.priority_threshold == exc_number)
      else $error("entry status update wrong");
   a_link_half: assert property (take |=> link_we // RQ15
      && link_register == {1'b0, $past(ret_addr[15:1])})
      else $error("link value wrong");
   a_vec_load: assert property (exc_taken |=> pc_load // RQ20
      && handler_pc == {vec_mem[exc_number][14:0], 1'b0} ##1 !pc_load)
      else $error("handler address wrong");
   a_return_restore: assert property (instr.valid && !busy_q // RQ17
      && instr.op == OP_EXCEPTION_RETURN && !take |=> status_q == $past(saved_q))
      else $error("return did not restore status");
   a_irq_gate: assert property (exc_taken && !$past(instr.valid) // RQ21
      |-> $past(status_q.interrupt_enable_bit)
      && $past(irqn_q) < $past(status_q.priority_threshold))
      else $error("request taken while masked");

   c_underflow: cover property (under ##2 pc_load);
   c_trap: cover property (trap ##2 pc_load);
   c_irq: cover property (take_irq ##1 exc_taken);
   c_return: cover property (instr.valid && instr.op == OP_EXCEPTION_RETURN && !take);
endmodule : wse_seq
